/* File: rtl/bus_rtc_calendar.sv */
// Bus-connected clock/calendar with digit registers and timed pulse.
// Assumes bus pins synchronous to i_clk; the board resolves wires.
//
// Notes on behaviour
// [RL1] Timekeeping divided from 32.768 kHz time base
// [RL2] 4-bit address/data, two selects, strobes, latch
// [RL3] Units digits count 0..9, carry to tens
// [RL4] Hour tens: bits 1..0 digit, bit 2 afternoon
// [RL5] Missing bits ignore writes, read zero
// [RL6] Host masks afternoon bit from hour tens
// [RL7] Busy bit is read only
// [RL8] Interrupt flag set by hardware, cleared by 0
// [RL9] Pulse periods 1/64 s, 1 s, 1 min, 1 h
// [RL10] Rate field and kind bit in register E
// [RL11] Mask bit silences timed pulse output
// [RL12] 12 or 24 hour format from register F
// [RL13] Leap years detected from year digits
// [RL14] 30-second adjust rounds seconds
// [RL15] Stop, hold and divider reset controls
// [RL16] Write captured on write strobe rising edge
// [RL17] Read suppressed when both strobes low
// [RL18] Address passes while latch strobe high
// [RL19] Hold defers one second until released
// [RL20] BCD carries ripple up; weekday per day
// [RL21] Data lines driven only during selected read
`timescale 1ns/10ps
`default_nettype none
module bus_rtc_calendar #(
  parameter int OSC_PER_SEC = rtc_pkg::OSC_HZ
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_osc_32k,
  input  wire logic [3:0] i_addr,
  input  wire logic [3:0] i_data,
  input  wire logic       i_ale,
  input  wire logic       i_chip_sel_active_low_n,
  input  wire logic       i_chip_sel_power_sense,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  output logic [3:0]      o_data,
  output logic            o_data_oe_n,
  output logic            o_timed_pulse_out,
  output logic            o_timed_pulse_out_oe_n
);
  import rtc_pkg::*;

  localparam int PWW = $clog2(STD_PULSE_EDGES + 1);

  typedef enum logic [1:0] {
    P_IDLE  = 2'b01,
    P_WIDTH = 2'b10
  } pulse_state_t;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [8:0] bcd_step(
    input logic [3:0] t, u, lt, lu, wt, wu);
    if ({t, u} >= {lt, lu}) begin
      bcd_step = {1'b1, wt, wu};
    end else if (u >= 4'h9) begin
      bcd_step = {1'b0, t + 4'h1, 4'h0}; // RL3
    end else begin
      bcd_step = {1'b0, t, u + 4'h1};
    end
  endfunction

  function automatic logic [7:0] month_last(
    input logic [7:0] mo, input logic leap);
    if (mo == 8'h02) begin
      month_last = leap ? 8'h29 : 8'h28; // RL13
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 ||
                 mo == 8'h11) begin
      month_last = 8'h30;
    end else begin
      month_last = 8'h31;
    end
  endfunction

  function automatic logic [3:0] field_mask(input logic [3:0] a);
    unique case (a)
      ADDR_SEC_T, ADDR_MIN_T, ADDR_HR_T, ADDR_WDAY: field_mask = 4'h7;
      ADDR_DATE_T: field_mask = 4'h3;
      ADDR_MON_T:  field_mask = 4'h1;
      default:     field_mask = 4'hf;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Front end and divider

  bus_req_t req;
  ticks_t   ticks;
  logic [3:0] ce_q, ce_d, cf_q, cf_d;

  rtc_bus_port u_port ( // RL2
    .i_clk                   (i_clk),
    .i_reset_n               (i_reset_n),
    .i_addr                  (i_addr),
    .i_data                  (i_data),
    .i_ale                   (i_ale),
    .i_chip_sel_active_low_n (i_chip_sel_active_low_n),
    .i_chip_sel_power_sense  (i_chip_sel_power_sense),
    .i_rd_n                  (i_rd_n),
    .i_wr_n                  (i_wr_n),
    .o_req                   (req)
  );

  rtc_prescaler #(.OSC_PER_SEC(OSC_PER_SEC)) u_div (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_osc     (i_osc_32k),
    .i_clear   (cf_q[CF_RST]),
    .i_stop    (cf_q[CF_STOP]),
    .o_ticks   (ticks)
  );

  //////////////////////////////////////////////////////////////////////
  // Time, calendar and control registers

  logic [3:0] dig_q [13];
  logic [3:0] dig_d [13];
  logic       hold_q, hold_d, pend_q, pend_d, busy_q, busy_d;
  logic       adj_q, adj_d, irq_q, irq_d;
  logic       hold_eff, adv, c_min, c_hr, c_day, c_mon, rate_ev, leap;
  logic       pw_done;
  logic [8:0] st;
  logic [7:0] last;
  pulse_state_t ps_q, ps_d;
  logic [PWW-1:0] pw_q, pw_d;

  always_comb begin
    dig_d  = dig_q;
    ce_d   = ce_q;
    cf_d   = cf_q;
    adj_d  = adj_q;
    hold_d = hold_q;
    irq_d  = irq_q;
    c_min  = 1'b0;
    c_hr   = 1'b0;
    c_day  = 1'b0;
    c_mon  = 1'b0;
    st     = '0;
    last   = '0;
    hold_eff = hold_q & i_chip_sel_power_sense;
    adv    = 1'b0;
    pend_d = pend_q;
    if (hold_eff) begin
      pend_d = pend_q | ticks.tick_sec; // RL19
    end else begin
      adv    = ticks.tick_sec | pend_q; // RL19
      pend_d = ticks.tick_sec & pend_q;
    end
    busy_d = adv;
    leap = dig_q[11][0] ? (dig_q[10] == 4'h2 || dig_q[10] == 4'h6)
                        : (dig_q[10] == 4'h0 || dig_q[10] == 4'h4 ||
                           dig_q[10] == 4'h8);
    if (adj_q) begin
      c_min    = dig_q[1] >= 4'h3; // RL14
      dig_d[0] = 4'h0;
      dig_d[1] = 4'h0;
      adj_d    = 1'b0;
    end else if (adv) begin
      st = bcd_step(dig_q[1], dig_q[0], 4'h5, 4'h9, 4'h0, 4'h0); // RL20
      {c_min, dig_d[1], dig_d[0]} = st;
    end
    if (c_min) begin
      st = bcd_step(dig_q[3], dig_q[2], 4'h5, 4'h9, 4'h0, 4'h0);
      {c_hr, dig_d[3], dig_d[2]} = st;
    end
    if (c_hr) begin
      if (cf_q[CF_24H]) begin // RL12
        st = bcd_step({2'b00, dig_q[5][1:0]}, dig_q[4],
                      4'h2, 4'h3, 4'h0, 4'h0);
        c_day    = st[8];
        dig_d[5] = {1'b0, 1'b0, st[5:4]};
        dig_d[4] = st[3:0];
      end else if ({dig_q[5][1:0], dig_q[4]} >= 6'h12) begin
        dig_d[5] = {1'b0, dig_q[5][H10_PM], 2'b00};
        dig_d[4] = 4'h1;
      end else if ({dig_q[5][1:0], dig_q[4]} == 6'h11) begin
        c_day    = dig_q[5][H10_PM];
        dig_d[5] = {1'b0, ~dig_q[5][H10_PM], 2'b01}; // RL4
        dig_d[4] = 4'h2;
      end else begin
        st = bcd_step({2'b00, dig_q[5][1:0]}, dig_q[4],
                      4'h9, 4'h9, 4'h0, 4'h0);
        dig_d[5] = {1'b0, dig_q[5][H10_PM], st[5:4]};
        dig_d[4] = st[3:0];
      end
    end
    if (c_day) begin
      last = month_last({dig_q[9], dig_q[8]}, leap);
      st = bcd_step(dig_q[7], dig_q[6], last[7:4], last[3:0],
                    4'h0, 4'h1);
      {c_mon, dig_d[7], dig_d[6]} = st;
      dig_d[12] = (dig_q[12] >= 4'h6) ? 4'h0 : dig_q[12] + 4'h1;
    end
    if (c_mon) begin
      st = bcd_step(dig_q[9], dig_q[8], 4'h1, 4'h2, 4'h0, 4'h1);
      dig_d[9] = st[7:4];
      dig_d[8] = st[3:0];
      if (st[8]) begin
        st = bcd_step(dig_q[11], dig_q[10], 4'h9, 4'h9, 4'h0, 4'h0);
        dig_d[11] = st[7:4];
        dig_d[10] = st[3:0];
      end
    end
    if (req.wr) begin
      if (req.addr <= ADDR_WDAY) begin
        dig_d[req.addr] = req.wdata & field_mask(req.addr); // RL5
      end else if (req.addr == ADDR_CTRL_D) begin
        hold_d = req.wdata[CD_HOLD]; // RL15
        adj_d  = req.wdata[CD_ADJ]; // RL14
        if (!req.wdata[CD_IRQ]) begin
          irq_d = 1'b0; // RL8
        end
      end else if (req.addr == ADDR_CTRL_E) begin
        ce_d = req.wdata; // RL10
      end else begin
        cf_d = req.wdata & CF_WMASK; // RL5
      end
    end
    if (!i_chip_sel_power_sense) begin
      hold_d = 1'b0;
    end
    unique case (rate_t'(ce_q[CE_RATE_LO +: 2])) // RL9
      RATE_64HZ: rate_ev = ticks.tick_64;
      RATE_SEC:  rate_ev = ticks.tick_sec;
      RATE_MIN:  rate_ev = c_min;
      RATE_HOUR: rate_ev = c_hr;
    endcase
    if (pw_done) begin
      irq_d = 1'b0;
    end
    if (rate_ev) begin
      irq_d = 1'b1; // RL8
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 13; i++) begin
        dig_q[i] <= DIGIT_RST;
      end
      ce_q   <= CTRL_RST;
      cf_q   <= CTRL_RST;
      hold_q <= 1'b0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      adj_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      dig_q  <= dig_d;
      ce_q   <= ce_d;
      cf_q   <= cf_d;
      hold_q <= hold_d;
      pend_q <= pend_d;
      busy_q <= busy_d;
      adj_q  <= adj_d;
      irq_q  <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Standard pulse width, read port and pin drivers

  logic [3:0] rdata;
  logic [3:0] data_q, data_d;
  logic       doe_n_q, doe_n_d, poe_n_q, poe_n_d;

  always_comb begin
    ps_d    = ps_q;
    pw_d    = pw_q;
    pw_done = 1'b0;
    unique case (ps_q)
      P_IDLE: begin
        if (rate_ev && !ce_q[CE_KIND]) begin
          ps_d = P_WIDTH;
          pw_d = '0;
        end
      end
      P_WIDTH: begin
        if (ce_q[CE_KIND]) begin
          ps_d = P_IDLE;
        end else if (pw_q == PWW'(STD_PULSE_EDGES)) begin
          pw_done = 1'b1;
          ps_d    = P_IDLE;
        end else if (ticks.osc_edge) begin
          pw_d = pw_q + PWW'(1);
        end
      end
    endcase
    if (req.addr <= ADDR_WDAY) begin
      rdata = dig_q[req.addr] & field_mask(req.addr); // RL5
      if (req.addr == ADDR_HR_T && cf_q[CF_24H]) begin
        rdata[H10_PM] = 1'b0; // RL12
      end
    end else if (req.addr == ADDR_CTRL_D) begin
      rdata = {1'b0, irq_q, busy_q, hold_q}; // RL7
    end else if (req.addr == ADDR_CTRL_E) begin
      rdata = ce_q;
    end else begin
      rdata = cf_q & CF_WMASK;
    end
    data_d  = req.rd ? rdata : data_q;
    doe_n_d = ~req.rd; // RL21
    poe_n_d = ~(irq_q & ~ce_q[CE_MASK]); // RL11
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ps_q    <= P_IDLE;
      pw_q    <= '0;
      data_q  <= 4'h0;
      doe_n_q <= 1'b1;
      poe_n_q <= 1'b1;
    end else begin
      ps_q    <= ps_d;
      pw_q    <= pw_d;
      data_q  <= data_d;
      doe_n_q <= doe_n_d;
      poe_n_q <= poe_n_d;
    end
  end

  assign o_data                 = data_q;
  assign o_data_oe_n            = doe_n_q;
  assign o_timed_pulse_out      = 1'b0;
  assign o_timed_pulse_out_oe_n = poe_n_q;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_held_tick;
    hold_eff && ticks.tick_sec;
  endsequence
  sequence s_release;
    !hold_eff ##0 pend_q;
  endsequence

  a_read_inhibit: assert property ( // RL17
    (!i_rd_n && !i_wr_n) |-> ##2 o_data_oe_n)
    else $error("read driven with both strobes low");
  a_drive_select: assert property ( // RL21
    !o_data_oe_n |-> $past(!i_rd_n && i_chip_sel_power_sense, 2))
    else $error("data driven outside selected read");
  a_unimpl_zero: assert property ( // RL5
    (req.rd && req.addr == ADDR_DATE_T) |=> o_data[3:2] == 2'b00)
    else $error("missing date tens bits read nonzero");
  a_irq_hw_only: assert property ( // RL8
    $rose(irq_q) |-> $past(rate_ev))
    else $error("interrupt flag set without event");
  a_mask_quiet: assert property ( // RL11
    ce_q[CE_MASK] |=> o_timed_pulse_out_oe_n)
    else $error("masked pulse output active");
  a_units_wrap: assert property ( // RL3
    (adv && !adj_q && !req.wr && dig_q[0] == 4'h9) |=> dig_q[0] == 4'h0)
    else $error("seconds units failed to wrap");
  a_hold_defer: assert property ( // RL19
    s_held_tick |=> pend_q)
    else $error("held tick not kept pending");
  a_release_apply: assert property ( // RL19
    s_release |=> busy_q)
    else $error("pending second not applied on release");
  a_write_capture: assert property ( // RL16
    (req.wr && req.addr == ADDR_CTRL_E) |=> ce_q == $past(req.wdata))
    else $error("register E write not captured");
  a_busy_readonly: assert property ( // RL7
    (req.wr && req.addr == ADDR_CTRL_D && !adv) |=> !busy_q)
    else $error("busy bit changed by write");

endmodule
`default_nettype wire

/* File: rtl/rtc_pkg.sv */
// Shared constants and carriers for the bus clock/calendar.
// Assumes a 200 MHz system clock and a 32.768 kHz time base pin.
package rtc_pkg;

  localparam int OSC_HZ          = 32768;
  localparam int SUB_DIV         = 512;
  localparam int STD_PULSE_EDGES = 256;

  localparam logic [3:0] ADDR_SEC_U  = 4'h0;
  localparam logic [3:0] ADDR_SEC_T  = 4'h1;
  localparam logic [3:0] ADDR_MIN_U  = 4'h2;
  localparam logic [3:0] ADDR_MIN_T  = 4'h3;
  localparam logic [3:0] ADDR_HR_U   = 4'h4;
  localparam logic [3:0] ADDR_HR_T   = 4'h5;
  localparam logic [3:0] ADDR_DATE_U = 4'h6;
  localparam logic [3:0] ADDR_DATE_T = 4'h7;
  localparam logic [3:0] ADDR_MON_U  = 4'h8;
  localparam logic [3:0] ADDR_MON_T  = 4'h9;
  localparam logic [3:0] ADDR_YR_U   = 4'ha;
  localparam logic [3:0] ADDR_YR_T   = 4'hb;
  localparam logic [3:0] ADDR_WDAY   = 4'hc;
  localparam logic [3:0] ADDR_CTRL_D = 4'hd;
  localparam logic [3:0] ADDR_CTRL_E = 4'he;
  localparam logic [3:0] ADDR_CTRL_F = 4'hf;

  localparam int CD_HOLD    = 0;
  localparam int CD_BUSY    = 1;
  localparam int CD_IRQ     = 2;
  localparam int CD_ADJ     = 3;
  localparam int CE_MASK    = 0;
  localparam int CE_KIND    = 1;
  localparam int CE_RATE_LO = 2;
  localparam int CF_RST     = 0;
  localparam int CF_STOP    = 1;
  localparam int CF_24H     = 2;
  localparam int H10_PM     = 2;

  localparam logic [3:0] CF_WMASK  = 4'h7;
  localparam logic [3:0] DIGIT_RST = 4'h0;
  localparam logic [3:0] CTRL_RST  = 4'h0;

  typedef enum logic [1:0] {
    RATE_64HZ = 2'h0,
    RATE_SEC  = 2'h1,
    RATE_MIN  = 2'h2,
    RATE_HOUR = 2'h3
  } rate_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [3:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic osc_edge;
    logic tick_64;
    logic tick_sec;
  } ticks_t;

endpackage

/* File: rtl/rtc_bus_port.sv */
// Parallel bus front end: address latch, strobe decode.
// Assumes all pins synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module rtc_bus_port (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic [3:0]        i_addr,
  input  wire logic [3:0]        i_data,
  input  wire logic              i_ale,
  input  wire logic              i_chip_sel_active_low_n,
  input  wire logic              i_chip_sel_power_sense,
  input  wire logic              i_rd_n,
  input  wire logic              i_wr_n,
  output rtc_pkg::bus_req_t      o_req
);
  import rtc_pkg::*;

  logic [3:0] latch_q, latch_d;
  logic [3:0] data_q, data_d;
  logic       wr_n_q, wr_n_d;
  bus_req_t   req_q, req_d;
  logic       sel;

  always_comb begin
    sel     = i_chip_sel_power_sense & ~i_chip_sel_active_low_n;
    latch_d = latch_q;
    if (i_ale && !i_chip_sel_active_low_n) begin
      latch_d = i_addr; // RL18
    end
    data_d       = i_data;
    wr_n_d       = i_wr_n;
    req_d.addr   = latch_d;
    req_d.wdata  = data_q;
    req_d.wr     = sel & ~wr_n_q & i_wr_n; // RL16
    req_d.rd     = sel & ~i_rd_n & i_wr_n; // RL17
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_q <= 4'h0;
      data_q  <= 4'h0;
      wr_n_q  <= 1'b1;
      req_q   <= '0;
    end else begin
      latch_q <= latch_d;
      data_q  <= data_d;
      wr_n_q  <= wr_n_d;
      req_q   <= req_d;
    end
  end

  assign o_req = req_q;
endmodule
`default_nettype wire

/* File: rtl/rtc_prescaler.sv */
// Divider chain from the 32.768 kHz time base to 64 Hz and 1 Hz.
// Assumes i_osc is a slow square wave synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module rtc_prescaler #(
  parameter int OSC_PER_SEC = rtc_pkg::OSC_HZ
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_osc,
  input  wire logic              i_clear,
  input  wire logic              i_stop,
  output rtc_pkg::ticks_t        o_ticks
);
  import rtc_pkg::*;

  localparam int CW   = $clog2(OSC_PER_SEC);
  // Edges per 1/64 s, scaled with a shortened time base
  localparam int FAST = OSC_PER_SEC * SUB_DIV / OSC_HZ;

  if (FAST < 1 || (OSC_PER_SEC * SUB_DIV) % OSC_HZ != 0) begin : g_bad
    $error("OSC_PER_SEC must be a multiple of OSC_HZ / SUB_DIV");
  end

  logic [CW-1:0] cnt_q, cnt_d;
  logic          osc_q;
  ticks_t        tk_q, tk_d;
  logic          edge_s;

  always_comb begin
    edge_s = i_osc & ~osc_q;
    cnt_d  = cnt_q;
    tk_d   = '0;
    tk_d.osc_edge = edge_s;
    if (i_clear) begin
      cnt_d = '0; // RL15
    end else if (edge_s && !i_stop) begin // RL15
      if (cnt_q == CW'(OSC_PER_SEC - 1)) begin
        cnt_d         = '0;
        tk_d.tick_sec = 1'b1; // RL1
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
      tk_d.tick_64 = (cnt_q % CW'(FAST)) == CW'(FAST - 1); // RL9
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      osc_q <= 1'b0;
      tk_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      osc_q <= i_osc;
      tk_q  <= tk_d;
    end
  end

  assign o_ticks = tk_q;
endmodule
`default_nettype wire

/* File: testbench/rtc_bus_host.sv */
// Host model for the 4-bit register bus of the clock/calendar.
// Assumes the bench resolves the data wire and drains exp_q.
`timescale 1ns/10ps
`default_nettype none
module rtc_bus_host (
  input  wire logic       i_clk,
  output logic [3:0]      o_addr,
  output logic [3:0]      o_data,
  output logic            o_data_en,
  output logic            o_ale,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n
);
  // Expected reads, {address, data}
  logic [7:0] exp_q[$];

  initial begin
    o_addr    = 4'h0;
    o_data    = 4'h0;
    o_data_en = 1'b0;
    o_ale     = 1'b0;
    o_cs_n    = 1'b1;
    o_rd_n    = 1'b1;
    o_wr_n    = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write; both=1 also lowers the read strobe
  task automatic wr(input logic [3:0] a, input logic [3:0] d,
                    input logic both);
    @(posedge i_clk);
    o_addr    <= a;
    o_ale     <= 1'b1;
    o_cs_n    <= 1'b0;
    o_data    <= d;
    o_data_en <= 1'b1;
    o_wr_n    <= 1'b0;
    o_rd_n    <= ~both;
    @(posedge i_clk);
    o_ale  <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    o_wr_n <= 1'b1;
    o_rd_n <= 1'b1;
    @(posedge i_clk);
    o_cs_n    <= 1'b1;
    o_data_en <= 1'b0;
    o_data    <= ~d;
    repeat (2) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read; chk=1 notes the expected value
  task automatic rd(input logic [3:0] a, input logic [3:0] e,
                    input logic chk);
    @(posedge i_clk);
    o_addr <= a;
    o_ale  <= 1'b1;
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    if (chk) exp_q.push_back({a, e});
    @(posedge i_clk);
    o_ale  <= 1'b0;
    o_addr <= ~a;
    repeat (3) @(posedge i_clk);
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_bus_rtc_calendar.sv */
// Self-checking bench for the bus clock/calendar.
// Assumes rtc_bus_host as bus partner and a shortened time base.
`timescale 1ns/10ps
`default_nettype none
module tb_bus_rtc_calendar;
  import rtc_pkg::*;

  localparam int          OSC_N = 1024;
  // One nibble per register, register 0 rightmost
  localparam logic [51:0] MASKS = 52'h7ff1f3f7f7f7f;
  localparam logic [51:0] INIT [4] = '{52'h6000228235959,
    52'h6010228235959, 52'h3991231115959, 52'h3991231515959};
  localparam logic [51:0] EXPV [4] = '{52'h0000229000000,
    52'h0010301000000, 52'h3991231520000, 52'h4000101120000};

  logic       clk;
  logic       reset_n;
  logic       osc;
  logic       pwr_sense;
  logic [3:0] h_addr, h_data, d_data;
  logic       h_data_en, h_ale, h_cs_n, h_rd_n, h_wr_n;
  logic       d_oe_n, p_out, p_oe_n, oe_prev;
  logic [7:0] note;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  wire logic [3:0] bus = (d_oe_n === 1'b0) ? d_data : h_data;
  wire logic       pin = (p_oe_n === 1'b0) ? p_out : 1'b1;

  bus_rtc_calendar #(.OSC_PER_SEC(OSC_N)) u_bus_rtc_calendar (
    .i_clk(clk), .i_reset_n(reset_n), .i_osc_32k(osc),
    .i_addr(h_addr), .i_data(bus), .i_ale(h_ale),
    .i_chip_sel_active_low_n(h_cs_n), .i_chip_sel_power_sense(pwr_sense),
    .i_rd_n(h_rd_n), .i_wr_n(h_wr_n), .o_data(d_data),
    .o_data_oe_n(d_oe_n), .o_timed_pulse_out(p_out),
    .o_timed_pulse_out_oe_n(p_oe_n));

  rtc_bus_host u_rtc_bus_host (
    .i_clk(clk), .o_addr(h_addr), .o_data(h_data), .o_data_en(h_data_en),
    .o_ale(h_ale), .o_cs_n(h_cs_n), .o_rd_n(h_rd_n), .o_wr_n(h_wr_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [3:0] seen,
                       input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic w(input logic [3:0] a, input logic [3:0] d);
    u_rtc_bus_host.wr(a, d, 1'b0);
  endtask

  task automatic r(input logic [3:0] a, input logic [3:0] e);
    u_rtc_bus_host.rd(a, e, 1'b1);
  endtask

  task automatic wait_pin(input logic lv, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pin !== lv && n < lim);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Time base at a quarter of the clock, and the run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc[0]) osc <= ~osc;
    if (cyc == 80000) begin
      n_fail++;
      end_sim();
    end
  end

  // Read results: oldest note against each new drive
  always @(posedge clk) begin
    oe_prev <= d_oe_n;
    if (d_oe_n === 1'b0 && h_data_en === 1'b1)
      check("bus contention", 4'h1, 4'h0);
    if (oe_prev === 1'b1 && d_oe_n === 1'b0) begin
      if (u_rtc_bus_host.exp_q.size() == 0)
        check("unexpected drive", 4'h1, 4'h0);
      else begin
        note = u_rtc_bus_host.exp_q.pop_front();
        check($sformatf("reg %h", note[7:4]), bus, note[3:0]);
        if (note[7:4] == ADDR_HR_T)
          check("hour digit", {2'b00, bus[1:0]}, {2'b00, note[1:0]});
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int low;
    logic [3:0] v;
    logic [3:0] m;
    logic [3:0] f;
    reset_n   = 1'b0;
    pwr_sense = 1'b1;
    osc       = 1'b0;
    void'($urandom(32'h7cbb97c0));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++)
      if (i != 13) r(4'(i), 4'h0);
    $display("reset values done");

    w(ADDR_CTRL_F, 4'h3);
    for (int i = 0; i < 13; i++) begin
      m = MASKS[4*i +: 4];
      v = 4'($urandom);
      if (m != 4'h0) begin
        w(4'(i), v);
        r(4'(i), v & m);
      end
    end
    w(ADDR_CTRL_D, 4'h0);
    w(ADDR_CTRL_D, 4'hf);
    r(ADDR_CTRL_D, 4'h1);
    w(ADDR_CTRL_D, 4'h0);
    w(ADDR_CTRL_F, 4'hf);
    r(ADDR_CTRL_F, CF_WMASK);
    $display("register access done");

    w(ADDR_MIN_U, 4'h3);
    w(ADDR_MIN_T, 4'h0);
    for (int k = 0; k < 2; k++) begin
      w(ADDR_SEC_U, 4'h5);
      w(ADDR_SEC_T, k ? 4'h1 : 4'h4);
      w(ADDR_CTRL_D, 4'h8);
      r(ADDR_SEC_T, 4'h0);
      r(ADDR_SEC_U, 4'h0);
      r(ADDR_MIN_U, 4'h4);
    end
    $display("adjust done");

    // One second across each rollover case
    for (int k = 0; k < 4; k++) begin
      f = (k < 2) ? 4'h4 : 4'h0;
      w(ADDR_CTRL_F, f | 4'h3);
      for (int i = 0; i < 13; i++) w(4'(i), INIT[k][4*i +: 4]);
      w(ADDR_CTRL_F, f);
      repeat (4600) @(posedge clk);
      w(ADDR_CTRL_F, f | 4'h2);
      for (int i = 0; i < 13; i++)
        r(4'(i), EXPV[k][4*i +: 4]);
      $display("calendar case %0d done", k);
    end

    w(ADDR_CTRL_F, 4'h1);
    w(ADDR_CTRL_E, 4'hf);
    w(ADDR_SEC_U, 4'h0);
    w(ADDR_CTRL_F, 4'h0);
    w(ADDR_CTRL_D, 4'h1);
    repeat (4300) @(posedge clk);
    r(ADDR_SEC_U, 4'h0);
    r(ADDR_CTRL_D, 4'h1);
    w(ADDR_CTRL_D, 4'h0);
    r(ADDR_SEC_U, 4'h1);
    $display("hold done");

    for (int k = 0; k < 4; k++) begin
      w(ADDR_CTRL_F, 4'h1);
      w(ADDR_CTRL_E, 4'hf);
      for (int i = 0; i < 4; i++) w(4'(i), i[0] ? 4'h5 : 4'h9);
      w(ADDR_CTRL_D, 4'h0);
      w(ADDR_CTRL_E, {2'(k), 2'b10});
      w(ADDR_CTRL_F, 4'h0);
      wait_pin(1'b0, 5000, n);
      check("pulse delay", 4'(k ? n > 3500 : n < 200), 4'h1);
      repeat (300) @(posedge clk);
      w(ADDR_CTRL_D, 4'h4);
      @(negedge clk);
      check("irq level", {3'h0, pin}, 4'h0);
      r(ADDR_CTRL_D, 4'h4);
      if (k != 0) begin
        w(ADDR_CTRL_D, 4'h0);
        repeat (2) @(negedge clk);
        check("irq cleared", {3'h0, pin}, 4'h1);
      end
      $display("rate %0d done", k);
    end

    w(ADDR_CTRL_F, 4'h1);
    w(ADDR_CTRL_D, 4'h0);
    w(ADDR_CTRL_E, 4'h4);
    w(ADDR_CTRL_F, 4'h0);
    wait_pin(1'b0, 5000, n);
    wait_pin(1'b1, 1200, n);
    check("pulse width", 4'(n > 900 && pin === 1'b1), 4'h1);
    $display("standard pulse done");

    w(ADDR_WDAY, 4'h5);
    u_rtc_bus_host.wr(ADDR_WDAY, 4'h2, 1'b1);
    pwr_sense <= 1'b0;
    u_rtc_bus_host.rd(ADDR_WDAY, 4'h0, 1'b0);
    w(ADDR_WDAY, 4'h6);
    pwr_sense <= 1'b1;
    r(ADDR_WDAY, 4'h2);
    $display("strobes and selects done");

    w(ADDR_CTRL_F, 4'h1);
    w(ADDR_CTRL_D, 4'h0);
    w(ADDR_CTRL_E, 4'h7);
    w(ADDR_CTRL_F, 4'h0);
    low = 0;
    repeat (4500) begin
      @(negedge clk);
      if (pin !== 1'b1) low++;
    end
    check("masked pulse", 4'(low != 0), 4'h0);
    r(ADDR_CTRL_D, 4'h4);
    $display("mask done");
    end_sim();
  end
endmodule
`default_nettype wire
